// [tws_if.sv]
`timescale 1ns/1ps

// Frame events and configuration shared between the top and the sequencer.
interface tws_if;
    logic        tick;
    logic        acq_en;
    logic        hw_frame;
    logic        hw_acq;
    logic        width_mode;
    logic        abort;
    logic [31:0] exposure;
    logic [31:0] overlap;
    logic [31:0] readout;
    logic        acq_wait;
    logic        frm_wait;
    logic        exposing;
    logic        frame_ovr;
    logic        acq_ovr;
    logic        drop;
    logic        frame_done;

    modport top (output tick, acq_en, hw_frame, hw_acq, width_mode, abort, exposure, overlap, readout,
                 input  acq_wait, frm_wait, exposing, frame_ovr, acq_ovr, drop, frame_done);
    modport seq (input  tick, acq_en, hw_frame, hw_acq, width_mode, abort, exposure, overlap, readout,
                 output acq_wait, frm_wait, exposing, frame_ovr, acq_ovr, drop, frame_done);
endinterface : tws_if

// [tws_pkg.sv]
package tws_pkg;

    localparam logic [7:0] TWS_REG_CTRL      = 8'h00;
    localparam logic [7:0] TWS_REG_EXPOSURE  = 8'h04;
    localparam logic [7:0] TWS_REG_OVERLAP   = 8'h08;
    localparam logic [7:0] TWS_REG_READOUT   = 8'h0C;
    localparam logic [7:0] TWS_REG_LINES     = 8'h10;
    localparam logic [7:0] TWS_REG_STATUS    = 8'h14;
    localparam logic [7:0] TWS_REG_IRQ_STAT  = 8'h18;
    localparam logic [7:0] TWS_REG_IRQ_MASK  = 8'h1C;

    localparam int TWS_CTRL_ACQ_EN      = 0;
    localparam int TWS_CTRL_HW_FRAME    = 1;
    localparam int TWS_CTRL_HW_ACQ      = 2;
    localparam int TWS_CTRL_WIDTH_MODE  = 3;
    localparam int TWS_CTRL_ABORT       = 4;

    localparam int TWS_LINE_DIR_BIT     = 0;
    localparam int TWS_LINE_GP_SRC_LSB  = 4;
    localparam int TWS_LINE_SP_SRC_LSB  = 8;

    localparam int TWS_IRQ_FRAME_OVR    = 0;
    localparam int TWS_IRQ_ACQ_OVR      = 1;
    localparam int TWS_IRQ_DROP         = 2;
    localparam int TWS_IRQ_FRAME_DONE   = 3;
    localparam int TWS_IRQ_BITS         = 4;

    localparam logic [31:0] TWS_CTRL_RST     = 32'h0000_0000;
    localparam logic [31:0] TWS_EXPOSURE_RST = 32'h0000_0064;
    localparam logic [31:0] TWS_OVERLAP_RST  = 32'h0000_0064;
    localparam logic [31:0] TWS_READOUT_RST  = 32'h0000_00C8;
    localparam logic [31:0] TWS_LINES_RST    = 32'h0000_0000;
    localparam logic [31:0] TWS_RD_UNMAPPED  = 32'h0000_0000;

    // Time base: one microsecond expressed in 4 ns cycles.
    localparam int TWS_CLK_MHZ       = 250;
    localparam int TWS_TIME_BASE_US  = 1;
    localparam int TWS_TICK_CYCLES   = TWS_TIME_BASE_US * TWS_CLK_MHZ;

    typedef enum logic [1:0] {
        TWS_SRC_LOW      = 2'b00,
        TWS_SRC_ACQ_WAIT = 2'b01,
        TWS_SRC_FRM_WAIT = 2'b10,
        TWS_SRC_EXPOSING = 2'b11
    } tws_src_t;

    localparam logic TWS_DIR_INPUT  = 1'b0;
    localparam logic TWS_DIR_OUTPUT = 1'b1;

endpackage : tws_pkg

// [tws_seq.sv]
`timescale 1ns/1ps

module tws_seq
(
    // System.
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Trigger pins, already synchronous.
    input  wire logic frame_trig_i,
    input  wire logic acq_trig_i,
    // Shared signals.
    tws_if.seq        bus
);
    import tws_pkg::*;

    typedef enum logic [1:0] {
        TWS_IDLE,
        TWS_ACQ_WAIT,
        TWS_RUN
    } tws_phase_t;

    typedef struct packed {
        tws_phase_t  phase;
        logic        ftrig_d;
        logic        atrig_d;
        logic        exposing;
        logic [31:0] exp_us;
        logic        reading;
        logic [31:0] rd_us;
        logic        frm_wait;
        logic        acq_wait;
        logic        frame_ovr;
        logic        acq_ovr;
        logic        drop;
        logic        frame_done;
    } tws_seq_state_t;

    tws_seq_state_t st;
    tws_seq_state_t next_st;

    logic        f_rise;
    logic        f_fall;
    logic        a_rise;
    logic [31:0] lead;
    logic        ready;

    always_comb begin
        f_rise = frame_trig_i & ~st.ftrig_d;
        f_fall = ~frame_trig_i & st.ftrig_d;
        a_rise = acq_trig_i & ~st.atrig_d;
        // Wait rises early enough that exposure ends as readout ends.
        lead  = bus.width_mode ? bus.overlap : bus.exposure;
        ready = st.phase == TWS_RUN && !st.exposing && (!st.reading || st.rd_us <= lead);

        next_st            = st;
        next_st.ftrig_d    = frame_trig_i;
        next_st.atrig_d    = acq_trig_i;
        next_st.frame_ovr  = 1'b0;
        next_st.acq_ovr    = 1'b0;
        next_st.drop       = 1'b0;
        next_st.frame_done = 1'b0;

        // Counters run in one microsecond units.
        if (bus.tick && st.exposing && !bus.width_mode && st.exp_us != 32'h0000_0000) begin
            next_st.exp_us = st.exp_us - 32'h0000_0001;
        end
        if (bus.tick && st.reading) begin
            if (st.rd_us <= 32'h0000_0001) begin
                next_st.reading    = 1'b0;
                next_st.frame_done = 1'b1;
            end else begin
                next_st.rd_us = st.rd_us - 32'h0000_0001;
            end
        end

        // Exposure end starts readout, or in width mode drops the frame if readout still runs.
        if (st.exposing && ((bus.width_mode && f_fall) || (!bus.width_mode && st.exp_us == 32'h0000_0000))) begin
            next_st.exposing = 1'b0;
            if (st.reading && bus.width_mode) begin
                next_st.drop      = 1'b1;
                next_st.frame_ovr = 1'b1;
            end else begin
                next_st.reading = 1'b1;
                next_st.rd_us   = bus.readout;
            end
        end

        unique case (st.phase)
            TWS_IDLE: begin
                next_st.frm_wait = 1'b0;
                next_st.acq_wait = 1'b0;
                if (bus.acq_en) begin
                    next_st.phase = bus.hw_acq ? TWS_ACQ_WAIT : TWS_RUN;
                end
            end
            TWS_ACQ_WAIT: begin
                next_st.acq_wait = 1'b1;
                if (a_rise && st.acq_wait) begin
                    next_st.acq_wait = 1'b0;
                    next_st.phase    = TWS_RUN;
                end
            end
            TWS_RUN: begin
                next_st.frm_wait = ready & bus.hw_frame;
                if (f_rise && bus.hw_frame && st.frm_wait) begin
                    // Trigger accepted: leave waiting and start exposure.
                    next_st.frm_wait = 1'b0;
                    next_st.exposing = 1'b1;
                    next_st.exp_us   = bus.exposure;
                end
            end
            default: next_st.phase = TWS_IDLE;
        endcase

        if (f_rise && bus.hw_frame && !(st.phase == TWS_RUN && st.frm_wait)) begin
            next_st.frame_ovr = 1'b1;
        end

        if (a_rise && bus.hw_acq && !(st.phase == TWS_ACQ_WAIT && st.acq_wait)) begin
            next_st.acq_ovr = 1'b1;
        end
        if (!bus.acq_en || bus.abort) begin
            next_st.phase    = TWS_IDLE;
            next_st.frm_wait = 1'b0;
            next_st.acq_wait = 1'b0;
            next_st.exposing = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st       <= '0;
            st.phase <= TWS_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign bus.acq_wait   = st.acq_wait;
    assign bus.frm_wait   = st.frm_wait;
    assign bus.exposing   = st.exposing;
    assign bus.frame_ovr  = st.frame_ovr;
    assign bus.acq_ovr    = st.acq_ovr;
    assign bus.drop       = st.drop;
    assign bus.frame_done = st.frame_done;
endmodule : tws_seq

// [tws_tick.sv]
`timescale 1ns/1ps

module tws_tick
(
    // System.
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Time-base pulse.
    output logic      tick_o
);
    import tws_pkg::*;

    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } tws_tick_state_t;

    tws_tick_state_t st;
    tws_tick_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.cnt == 8'(TWS_TICK_CYCLES - 1)) begin
            next_st.cnt  = 8'h00;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick_o = st.tick;
endmodule : tws_tick

// [tws_top.sv]
// What this block does
// - Frame wait goes high on entering the waiting-for-frame-trigger state.
// - Frame wait goes low when an external frame trigger is accepted.
// - A frame trigger while not waiting is ignored and flags an overtrigger.
// - Frame wait is produced only while hardware frame triggering is enabled.
// - Timed mode: wait rise timed from exposure time and readout end.
// - Width mode: wait rise timed from overlap limit and readout end.
// - Overlap limit counts whole microseconds, unsigned.
// - General line shows frame wait when set as output and selected.
// - General line shows acquisition wait when set as output and selected.
// - Spare link line shows the selected wait signal, no direction needed.
// - Exposure-active is high from exposure start to exposure end.
// - Acquisition wait is high while waiting for an acquisition trigger.
// - Width mode exposure ending during readout drops the frame with overtrigger.
`timescale 1ns/1ps

module tws_top
(
    // System.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave.
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // Trigger inputs.
    input  wire logic        external_frame_start_input_i,
    input  wire logic        external_acquisition_start_input_i,
    // Output lines.
    output logic             general_purpose_line_o,
    output logic             general_purpose_line_oe_o,
    output logic             spare_link_output_o,
    output logic             exposure_active_indicator_o,
    output logic             irq_o
);
    import tws_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    tws_if bus ();

    tws_tick u_tick (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (bus.tick)
    );

    tws_seq u_seq (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .frame_trig_i (external_frame_start_input_i),
        .acq_trig_i   (external_acquisition_start_input_i),
        .bus          (bus.seq)
    );

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [31:0]             ctrl;
        logic [31:0]             exposure;
        logic [31:0]             overlap;
        logic [31:0]             readout;
        logic [31:0]             lines;
        logic [TWS_IRQ_BITS-1:0] irq_stat;
        logic [TWS_IRQ_BITS-1:0] irq_mask;
        logic [31:0]             dat;
        logic                    ack;
        logic                    gp;
        logic                    gp_oe;
        logic                    spare;
        logic                    expo;
        logic                    irq;
    } tws_top_state_t;

    tws_top_state_t st;
    tws_top_state_t next_st;

    logic [TWS_IRQ_BITS-1:0] events;
    logic [31:0]             rdata;
    logic                    req;
    tws_src_t                gp_src;
    tws_src_t                sp_src;
    logic                    frm_wait_vis;

    assign bus.acq_en     = st.ctrl[TWS_CTRL_ACQ_EN];
    assign bus.hw_frame   = st.ctrl[TWS_CTRL_HW_FRAME];
    assign bus.hw_acq     = st.ctrl[TWS_CTRL_HW_ACQ];
    assign bus.width_mode = st.ctrl[TWS_CTRL_WIDTH_MODE];
    assign bus.abort      = st.ctrl[TWS_CTRL_ABORT];
    assign bus.exposure   = st.exposure;
    assign bus.overlap    = st.overlap;
    assign bus.readout    = st.readout;

    // Write a 32-bit word honoring byte selects.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic line_value(input tws_src_t s, input logic fw, input logic aw, input logic ex);
        logic v;
        v = 1'b0;
        unique case (s)
            TWS_SRC_LOW:      v = 1'b0;
            TWS_SRC_ACQ_WAIT: v = aw;
            TWS_SRC_FRM_WAIT: v = fw;
            TWS_SRC_EXPOSING: v = ex;
        endcase
        return v;
    endfunction

    always_comb begin
        events[TWS_IRQ_FRAME_OVR]  = bus.frame_ovr;
        events[TWS_IRQ_ACQ_OVR]    = bus.acq_ovr;
        events[TWS_IRQ_DROP]       = bus.drop;
        events[TWS_IRQ_FRAME_DONE] = bus.frame_done;
        req = cyc_i & stb_i & ~st.ack;

        unique case (adr_i)
            TWS_REG_CTRL:     rdata = st.ctrl;
            TWS_REG_EXPOSURE: rdata = st.exposure;
            TWS_REG_OVERLAP:  rdata = st.overlap;
            TWS_REG_READOUT:  rdata = st.readout;
            TWS_REG_LINES:    rdata = st.lines;
            TWS_REG_STATUS:   rdata = {29'h0, bus.exposing, bus.frm_wait, bus.acq_wait};
            TWS_REG_IRQ_STAT: rdata = {{(32-TWS_IRQ_BITS){1'b0}}, st.irq_stat};
            TWS_REG_IRQ_MASK: rdata = {{(32-TWS_IRQ_BITS){1'b0}}, st.irq_mask};
            default:          rdata = TWS_RD_UNMAPPED;
        endcase

        next_st     = st;
        next_st.ack = req;
        if (req) begin
            next_st.dat = we_i ? st.dat : rdata;
        end
        if (req && we_i) begin
            unique case (adr_i)
                TWS_REG_CTRL:     next_st.ctrl     = merge(st.ctrl, dat_i, sel_i);
                TWS_REG_EXPOSURE: next_st.exposure = merge(st.exposure, dat_i, sel_i);
                TWS_REG_OVERLAP:  next_st.overlap  = merge(st.overlap, dat_i, sel_i);
                TWS_REG_READOUT:  next_st.readout  = merge(st.readout, dat_i, sel_i);
                TWS_REG_LINES:    next_st.lines    = merge(st.lines, dat_i, sel_i);
                TWS_REG_IRQ_MASK: next_st.irq_mask = sel_i[0] ? dat_i[TWS_IRQ_BITS-1:0] : st.irq_mask;
                default:          ;
            endcase
        end
        // A status read clears the bits; a same-cycle event still sets.
        if (req && !we_i && adr_i == TWS_REG_IRQ_STAT) begin
            next_st.irq_stat = events;
        end else begin
            next_st.irq_stat = st.irq_stat | events;
        end
        next_st.irq = |(next_st.irq_stat & next_st.irq_mask);

        gp_src       = tws_src_t'(st.lines[TWS_LINE_GP_SRC_LSB +: 2]);
        sp_src       = tws_src_t'(st.lines[TWS_LINE_SP_SRC_LSB +: 2]);
        frm_wait_vis = bus.frm_wait & st.ctrl[TWS_CTRL_HW_FRAME];
        next_st.gp_oe = st.lines[TWS_LINE_DIR_BIT] == TWS_DIR_OUTPUT;
        // General line only drives when set as output.
        next_st.gp    = next_st.gp_oe & line_value(gp_src, frm_wait_vis, bus.acq_wait, bus.exposing);
        next_st.spare = line_value(sp_src, frm_wait_vis, bus.acq_wait, bus.exposing);
        next_st.expo  = bus.exposing;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st          <= '0;
            st.ctrl     <= TWS_CTRL_RST;
            st.exposure <= TWS_EXPOSURE_RST;
            st.overlap  <= TWS_OVERLAP_RST;
            st.readout  <= TWS_READOUT_RST;
            st.lines    <= TWS_LINES_RST;
        end else begin
            st <= next_st;
        end
    end

    assign dat_o                       = st.dat;
    assign ack_o                       = st.ack;
    assign general_purpose_line_o      = st.gp;
    assign general_purpose_line_oe_o   = st.gp_oe;
    assign spare_link_output_o         = st.spare;
    assign exposure_active_indicator_o = st.expo;
    assign irq_o                       = st.irq;
endmodule : tws_top

// [tws_top_checker.sv]
`timescale 1ns/1ps

module tws_top_checker
    import tws_pkg::*;
(
    // System.
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Bus.
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [31:0] dat_i,
    input wire logic        ack_o,
    // Lines.
    input wire logic        external_frame_start_input_i,
    input wire logic        general_purpose_line_o,
    input wire logic        general_purpose_line_oe_o,
    input wire logic        spare_link_output_o,
    input wire logic        exposure_active_indicator_o,
    input wire logic        irq_o
);
    // Bus writes are shadowed; enable, source, trigger and irq checks wait four quiet cycles after one.
    logic [9:0] lines;
    logic       hwf;
    logic [3:0] mask;
    logic [2:0] quiet;
    logic       wr;
    logic       ok;
    logic       fsel;
    assign wr   = cyc_i && stb_i && we_i && !ack_o;
    assign ok   = quiet == 3'h4;
    assign fsel = ok && lines[9:8] == TWS_SRC_FRM_WAIT;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lines <= 10'h000;
            hwf   <= 1'b0;
            mask  <= 4'h0;
            quiet <= 3'h0;
        end else begin
            quiet <= wr ? 3'h0 : (ok ? quiet : quiet + 3'h1);
            if (wr && adr_i == TWS_REG_LINES) begin
                lines <= dat_i[9:0];
            end
            if (wr && adr_i == TWS_REG_CTRL) begin
                hwf <= dat_i[TWS_CTRL_HW_FRAME];
            end
            if (wr && adr_i == TWS_REG_IRQ_MASK) begin
                mask <= dat_i[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_ack_answer;
        cyc_i && stb_i && !ack_o |=> ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("bus request not answered");
    property p_ack_drop;
        ack_o |=> !ack_o;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("ack longer than one cycle");
    property p_oe_dir;
        ok |-> general_purpose_line_oe_o == lines[TWS_LINE_DIR_BIT];
    endproperty
    a_oe_dir: assert property (p_oe_dir) else $error("line enable differs from direction");
    property p_gp_in;
        !general_purpose_line_oe_o |-> !general_purpose_line_o;
    endproperty
    a_gp_in: assert property (p_gp_in) else $error("input line shows a value");
    property p_same_src;
        ok && lines[0] && lines[5:4] == lines[9:8] |-> general_purpose_line_o == spare_link_output_o;
    endproperty
    a_same_src: assert property (p_same_src) else $error("lines disagree on one source");
    property p_hw_off;
        fsel && !hwf |-> !spare_link_output_o;
    endproperty
    a_hw_off: assert property (p_hw_off) else $error("frame wait without hw trigger");
    property p_accept;
        fsel && hwf && spare_link_output_o && $rose(external_frame_start_input_i)
            |-> ##[1:3] exposure_active_indicator_o && !spare_link_output_o;
    endproperty
    a_accept: assert property (p_accept) else $error("trigger not accepted");
    property p_reject;
        fsel && !spare_link_output_o && !exposure_active_indicator_o && $rose(external_frame_start_input_i)
            ##1 !spare_link_output_o |=> !exposure_active_indicator_o [*2];
    endproperty
    a_reject: assert property (p_reject) else $error("early trigger started exposure");
    property p_irq_mask;
        ok && mask == 4'h0 |-> !irq_o;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq with all masked");
    property p_exp_hold;
        $rose(exposure_active_indicator_o) |-> exposure_active_indicator_o [*8];
    endproperty
    a_exp_hold: assert property (p_exp_hold) else $error("exposure too short");
endmodule // tws_top_checker

bind tws_top tws_top_checker u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i),
    .ack_o(ack_o), .external_frame_start_input_i(external_frame_start_input_i),
    .general_purpose_line_o(general_purpose_line_o), .general_purpose_line_oe_o(general_purpose_line_oe_o),
    .spare_link_output_o(spare_link_output_o), .exposure_active_indicator_o(exposure_active_indicator_o),
    .irq_o(irq_o)
);

// [tws_top_tb.sv]
`timescale 1ns/1ps

module tws_top_tb;
    import tws_pkg::*;

    logic        clk_i  = 1'b0;
    logic        rst_i  = 1'b1;
    logic        cyc    = 1'b0;
    logic        stb    = 1'b0;
    logic        we     = 1'b0;
    logic [7:0]  adr    = 8'h00;
    logic [31:0] dat    = 32'h0000_0000;
    logic        astart = 1'b0;
    logic        fire   = 1'b0;
    logic        frc    = 1'b0;
    logic [15:0] width  = 16'h0001;
    logic [31:0] dat_o;
    logic [31:0] q;
    logic        ack_o, fstart, gp, gp_oe, sp, expo, irq;
    int          n_errors  = 0;
    int          cmp_count = 0;
    int          n;
    // Rows: control nibble, line register, then expected general line, its enable and spare line.
    localparam logic [19:0] ROWS [7] = '{20'h7_0116, 20'h7_2100, 20'h7_1001, 20'h3_2217,
                                         20'h3_1112, 20'h1_2212, 20'h3_0200};
    localparam logic [39:0] RST [7] = '{{TWS_REG_CTRL, TWS_CTRL_RST}, {TWS_REG_EXPOSURE, TWS_EXPOSURE_RST},
        {TWS_REG_OVERLAP, TWS_OVERLAP_RST}, {TWS_REG_READOUT, TWS_READOUT_RST}, {TWS_REG_LINES, TWS_LINES_RST},
        {TWS_REG_IRQ_MASK, 32'h0000_0000}, {8'h20, TWS_RD_UNMAPPED}};

    always #2 clk_i = ~clk_i;

    tws_top dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf),
        .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .external_frame_start_input_i(fstart),
        .external_acquisition_start_input_i(astart), .general_purpose_line_o(gp),
        .general_purpose_line_oe_o(gp_oe), .spare_link_output_o(sp), .exposure_active_indicator_o(expo),
        .irq_o(irq)
    );
    tws_trig_src u_src (
        .clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .force_i(frc), .width_i(width), .wait_i(sp), .trig_o(fstart)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("BAD %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (ack_o !== 1'b1 && i < 20);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack_o !== 1'b1) begin
            n_errors++;
            $display("BAD %0t no ack", $time);
            close_out;
        end
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return expo;
            1: return sp;
            2: return fstart;
            3: return irq;
            default: return gp;
        endcase
    endfunction

    // Waits for the chosen output level; running out ends the run.
    task automatic wait_for(input int s, input logic lvl, input int lim);
        n = 0;
        while (pick(s) !== lvl) begin
            @(posedge clk_i);
            n++;
            if (n > lim) begin
                n_errors++;
                $display("BAD %0t wait ran out", $time);
                close_out;
            end
        end
    endtask

    task automatic shoot(input logic f, input logic [15:0] w);
        frc   <= f;
        width <= w;
        fire  <= 1'b1;
        @(posedge clk_i);
        wait_for(2, 1'b1, 4000);
        fire <= 1'b0;
        frc  <= 1'b0;
    endtask

    // One accepted frame: exposure length, then the gap from exposure end to the next wait.
    task automatic frame(input logic [15:0] w, input int lo, input int hi);
        shoot(1'b0, w);
        wait_for(0, 1'b1, 4);
        wait_for(0, 1'b0, 3000);
        chk_rng(n, lo, hi);
        wait_for(1, 1'b1, 3000);
        chk_rng(n, 1240, 1510);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int r = 0; r < 7; r++) begin
            wb(1'b1, TWS_REG_CTRL, 32'h0000_0000);
            wb(1'b1, TWS_REG_LINES, 32'(ROWS[r][15:4]));
            wb(1'b1, TWS_REG_CTRL, 32'(ROWS[r][19:16]));
            repeat (4) @(posedge clk_i);
            chk(32'({gp, gp_oe, sp}), 32'(ROWS[r][2:0]));
        end
        wb(1'b1, TWS_REG_CTRL, 32'h0000_0000);
        wb(1'b1, TWS_REG_LINES, 32'h0000_0211);
        wb(1'b1, TWS_REG_CTRL, 32'h0000_0007);
        wait_for(4, 1'b1, 10);
        astart <= 1'b1;
        wait_for(4, 1'b0, 4);
        wait_for(1, 1'b1, 10);
        astart <= 1'b0;
        // Mid-run reset, then register defaults.
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(32'({gp, gp_oe, sp, expo, irq}), 32'h0000_0000);
        foreach (RST[i]) begin
            wb(1'b0, RST[i][39:32], 32'h0000_0000);
            chk(q, RST[i][31:0]);
        end
        wb(1'b1, TWS_REG_EXPOSURE, 32'h0000_0002);
        wb(1'b1, TWS_REG_READOUT, 32'h0000_0008);
        wb(1'b1, TWS_REG_LINES, 32'h0000_0221);
        wb(1'b1, TWS_REG_IRQ_MASK, 32'h0000_0001);
        wb(1'b1, TWS_REG_CTRL, 32'h0000_0003);
        wait_for(1, 1'b1, 20);
        frame(16'h0001, 250, 504);
        shoot(1'b0, 16'h0001);
        wait_for(0, 1'b1, 4);
        wait_for(0, 1'b0, 600);
        repeat (400) @(posedge clk_i);
        wb(1'b0, TWS_REG_IRQ_STAT, 32'h0000_0000);
        shoot(1'b1, 16'h0001);
        wait_for(3, 1'b1, 6);
        wb(1'b0, TWS_REG_IRQ_STAT, 32'h0000_0000);
        chk(q & 32'h0000_0007, 32'h0000_0001);
        wb(1'b0, TWS_REG_IRQ_STAT, 32'h0000_0000);
        chk(q & 32'h0000_0001, 32'h0000_0000);
        wait_for(3, 1'b0, 4);
        wait_for(1, 1'b1, 3000);
        wb(1'b1, TWS_REG_CTRL, 32'h0000_0000);
        wb(1'b1, TWS_REG_OVERLAP, 32'h0000_0002);
        wb(1'b1, TWS_REG_CTRL, 32'h0000_000B);
        wait_for(1, 1'b1, 1000);
        frame(16'h01F4, 500, 502);
        wb(1'b0, TWS_REG_IRQ_STAT, 32'h0000_0000);
        // Pulse shorter than the overlap limit.
        shoot(1'b0, 16'h0064);
        wait_for(3, 1'b1, 300);
        wb(1'b0, TWS_REG_IRQ_STAT, 32'h0000_0000);
        chk(q & 32'h0000_0005, 32'h0000_0005);
        close_out;
    end
endmodule // tws_top_tb

// [tws_trig_src.sv]
`timescale 1ns/1ps

module tws_trig_src (
    // System.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Requests from the bench.
    input  wire logic        fire_i,
    input  wire logic        force_i,
    input  wire logic [15:0] width_i,
    // Camera side.
    input  wire logic        wait_i,
    output logic             trig_o
);
    logic [15:0] cnt;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_o <= 1'b0;
            cnt    <= 16'h0000;
        end else if (trig_o) begin
            // The width is counted here, so the pulse ignores what the camera does meanwhile.
            cnt <= cnt - 16'h0001;
            if (cnt == 16'h0001) begin
                trig_o <= 1'b0;
            end
        end else if (fire_i && (wait_i || force_i)) begin
            trig_o <= 1'b1;
            cnt    <= width_i;
        end
    end
endmodule // tws_trig_src
